// ===== rtl/ctu_map.vh
// Purpose: Constants for the control timer unit event/compare block
// Assumes: 32-bit register port, byte addressing
// Notes:   Offsets are byte addresses
`ifndef CTU_MAP_VH
`define CTU_MAP_VH
`define CTU_OFF_CTRL        8'h00
`define CTU_OFF_EVCTRL      8'h04
`define CTU_OFF_CMD         8'h08
`define CTU_OFF_IEN_CLR     8'h0C
`define CTU_OFF_IEN_SET     8'h10
`define CTU_OFF_FLAGS       8'h14
`define CTU_OFF_COUNT       8'h18
`define CTU_OFF_TOP         8'h1C
`define CTU_OFF_DRV         8'h20
`define CTU_OFF_STATUS      8'h24
`define CTU_OFF_CB0         8'h30
`define CTU_OFF_CV0         8'h40
`define CTU_NCH             2
`define CTU_CW              16
`define CTU_EV_OFF          3'h0
`define CTU_EV_DIR          3'h2
`define CTU_EV_START        3'h3
`define CTU_EV_INCDEC       3'h4
`define CTU_EV_COUNT        3'h5
`define CTU_EV_FAULT        3'h7
`define CTU_CMD_UPDATE      3'h3
`define CTU_IRQ_WRAP        0
`define CTU_IRQ_RETRIG      1
`define CTU_IRQ_COUNTER     2
`define CTU_IRQ_MISHAP      3
`define CTU_IRQ_DBGFLT      11
`define CTU_IEN_MASK        16'h080F
`define CTU_TOP_RST         16'hFFFF
`endif

// ===== rtl/ctu_event_edge.v
// Purpose: One-cycle pulse on rising edge of an event line
// Assumes: Event line synchronous to mclk
// Notes:   None
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_event_edge (
  // Clock and reset
  input  wire mclk,
  input  wire rstn,
  // Event
  input  wire level,
  output wire pulse
);
  reg last;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end
  assign pulse = level & ~last;
endmodule // ctu_event_edge

// ===== rtl/ctu_compare_chan.v
// Purpose: One compare channel with double-buffered compare value
// Assumes: Counter value supplied every cycle
// Notes:   Compare mode only after reset
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_compare_chan (
  // Clock and reset
  input  wire                 mclk,
  input  wire                 rstn,
  // Buffer write and update
  input  wire                 buf_we,
  input  wire [`CTU_CW-1:0]   buf_wdata,
  input  wire                 load,
  // Counter
  input  wire [`CTU_CW-1:0]   count,
  output reg  [`CTU_CW-1:0]   compare_value,
  output reg  [`CTU_CW-1:0]   compare_buffer,
  output wire                 match,
  output wire                 wave
);
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      compare_value  <= {`CTU_CW{1'b0}};
      compare_buffer <= {`CTU_CW{1'b0}};
    end else begin
      if (buf_we) begin
        compare_buffer <= buf_wdata;
      end
      if (load) begin
        compare_value <= buf_we ? buf_wdata : compare_buffer;
      end
    end
  end
  assign match = (count == compare_value);
  assign wave  = (count <  compare_value);
endmodule // ctu_compare_chan

// ===== rtl/ctu_core.v
// Purpose: Control timer unit event actions, compare channels and irq enables
// Assumes: Single clock, synchronous event inputs, one-cycle register strobes
// Notes:   Register read data valid in the cycle after the read strobe
//
// What this block does
// - With input-0 set to start, enabling waits for the next event before counting.
// - Once started by an event, later start events do nothing.
// - With input-0 set to count, each event steps the counter in the current direction.
// - With input-1 set to direction, the event level sets the stored direction bit.
// - With input-0 set to increment, each event on line A adds one whatever the direction, except in a cycle with a decrement event on line B.
// - With input-1 set to decrement and input-0 not set to count, each line B event subtracts one whatever the direction, unless line A increments that cycle.
// - A fault event on a fault-configured input stops the counter and forces override outputs.
// - With event behaviour off, enabling starts counting at once.
// - Each channel works in compare mode after reset.
// - The counter is compared each cycle to each channel's compare value.
// - Compare values load from their buffers only at update or on the force-update command.
// - Writing one to the debug-fault or mishap clear bit disables it; reads show enables.
// - Writing one to the counter, retrigger or wrap clear bit disables it; reads show enables.
// - Writing zero to a clear bit leaves that enable alone.
// - The set register enables bits, and set and clear views share the same enables.
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_core (
  // Clock and reset
  input  wire                 mclk,
  input  wire                 rstn,
  // Register port
  input  wire [7:0]           addr,
  input  wire [31:0]          wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [31:0]          rdata,
  // Event inputs
  input  wire                 counter_event_line_a,
  input  wire                 counter_event_line_b,
  // Outputs
  output reg  [`CTU_NCH-1:0]  wave_out,
  output reg  [`CTU_CW-1:0]   count_out,
  output reg                  irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg                     enable;
  reg                     dir_down;
  reg                     faulted;
  reg  [2:0]              input0_event_behaviour;
  reg  [2:0]              input1_event_behaviour;
  reg  [`CTU_NCH-1:0]     permanent_fault_override_en;
  reg  [`CTU_NCH-1:0]     permanent_fault_override_level;
  reg  [15:0]             irq_en;
  reg  [15:0]             flags;
  reg  [`CTU_CW-1:0]      count;
  reg  [`CTU_CW-1:0]      top;
  reg  [`CTU_CW-1:0]      next_count;
  reg                     wrap;
  reg                     retrig;
  reg                     stepped;

  wire                    ev_a;
  wire                    ev_b;
  wire                    w_ctrl   = wr && addr == `CTU_OFF_CTRL;
  wire                    w_ev     = wr && addr == `CTU_OFF_EVCTRL;
  wire                    w_cmd    = wr && addr == `CTU_OFF_CMD;
  wire                    force_up = w_cmd && wdata[2:0] == `CTU_CMD_UPDATE;
  wire                    running  = state == ST_RUN;
  wire                    fault_ev = (input0_event_behaviour == `CTU_EV_FAULT && ev_a) ||
                                     (input1_event_behaviour == `CTU_EV_FAULT && ev_b);
  wire                    update   = running && wrap;
  wire [`CTU_NCH-1:0]     match;
  wire [`CTU_NCH-1:0]     wave;
  wire [`CTU_CW*`CTU_NCH-1:0] cv_all;
  wire [`CTU_CW*`CTU_NCH-1:0] cb_all;
  wire [15:0]             ev_flags;

  ctu_event_edge u_edge_a (
    .mclk  (mclk),
    .rstn  (rstn),
    .level (counter_event_line_a),
    .pulse (ev_a)
  );

  ctu_event_edge u_edge_b (
    .mclk  (mclk),
    .rstn  (rstn),
    .level (counter_event_line_b),
    .pulse (ev_b)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CTU_NCH; gi = gi + 1) begin : g_ch
      ctu_compare_chan u_ch (
        .mclk           (mclk),
        .rstn           (rstn),
        .buf_we         (wr && addr == `CTU_OFF_CB0 + 8'h04 * gi),
        .buf_wdata      (wdata[`CTU_CW-1:0]),
        .load           (update || force_up),
        .count          (count),
        .compare_value  (cv_all[gi*`CTU_CW +: `CTU_CW]),
        .compare_buffer (cb_all[gi*`CTU_CW +: `CTU_CW]),
        .match          (match[gi]),
        .wave           (wave[gi])
      );
    end
  endgenerate

  // Start state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enable && !faulted) begin
          if (input0_event_behaviour == `CTU_EV_START) begin
            next_state = ST_WAIT;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_WAIT: begin
        if (ev_a) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!enable || faulted || fault_ev) begin
      next_state = ST_IDLE;
    end
  end

  // Counter step
  always @* begin
    next_count = count;
    wrap       = 1'b0;
    stepped    = 1'b0;
    if (running && !fault_ev) begin
      if (input0_event_behaviour == `CTU_EV_COUNT) begin
        stepped = ev_a;
        if (ev_a) begin
          next_count = dir_down ? count - 16'h0001 : count + 16'h0001;
        end
      end else if (input0_event_behaviour == `CTU_EV_INCDEC ||
                   input1_event_behaviour == `CTU_EV_INCDEC) begin
        stepped = 1'b1;
        if (input0_event_behaviour == `CTU_EV_INCDEC && ev_a &&
            !(input1_event_behaviour == `CTU_EV_INCDEC && ev_b)) begin
          next_count = count + 16'h0001;
        end else if (input1_event_behaviour == `CTU_EV_INCDEC && ev_b &&
                     !(input0_event_behaviour == `CTU_EV_INCDEC && ev_a)) begin
          next_count = count - 16'h0001;
        end else begin
          stepped = 1'b0;
        end
      end else begin
        stepped    = 1'b1;
        next_count = dir_down ? count - 16'h0001 : count + 16'h0001;
      end
      if (stepped) begin
        if (!dir_down && count == top && next_count != count - 16'h0001) begin
          next_count = 16'h0000;
          wrap       = 1'b1;
        end else if (dir_down && count == 16'h0000 && next_count != 16'h0001) begin
          next_count = top;
          wrap       = 1'b1;
        end
      end
    end
  end

  assign ev_flags = {4'h0, fault_ev, 7'h00, fault_ev, stepped, retrig, wrap};

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state                          <= ST_IDLE;
      enable                         <= 1'b0;
      dir_down                       <= 1'b0;
      faulted                        <= 1'b0;
      input0_event_behaviour         <= `CTU_EV_OFF;
      input1_event_behaviour         <= `CTU_EV_OFF;
      permanent_fault_override_en    <= {`CTU_NCH{1'b0}};
      permanent_fault_override_level <= {`CTU_NCH{1'b0}};
      irq_en                         <= 16'h0000;
      flags                          <= 16'h0000;
      count                          <= {`CTU_CW{1'b0}};
      top                            <= `CTU_TOP_RST;
      retrig                         <= 1'b0;
      rdata                          <= 32'h0000_0000;
      wave_out                       <= {`CTU_NCH{1'b0}};
      count_out                      <= {`CTU_CW{1'b0}};
      irq                            <= 1'b0;
    end else begin
      state   <= next_state;
      count   <= (w_ctrl && wdata[2]) ? {`CTU_CW{1'b0}} : next_count;
      retrig  <= (state == ST_WAIT) && ev_a;
      if (fault_ev) begin
        faulted <= 1'b1;
      end else if (w_ctrl && wdata[3]) begin
        faulted <= 1'b0;
      end
      if (w_ctrl) begin
        enable <= wdata[0];
      end
      if (input1_event_behaviour == `CTU_EV_DIR) begin
        dir_down <= counter_event_line_b;
      end else if (w_ctrl) begin
        dir_down <= wdata[1];
      end
      if (w_ev) begin
        input0_event_behaviour <= wdata[2:0];
        input1_event_behaviour <= wdata[6:4];
      end
      if (wr && addr == `CTU_OFF_TOP) begin
        top <= wdata[`CTU_CW-1:0];
      end
      if (wr && addr == `CTU_OFF_DRV) begin
        permanent_fault_override_en    <= wdata[`CTU_NCH-1:0];
        permanent_fault_override_level <= wdata[8+`CTU_NCH-1:8];
      end
      if (wr && addr == `CTU_OFF_IEN_CLR) begin
        irq_en <= irq_en & ~(wdata[15:0] & `CTU_IEN_MASK);
      end else if (wr && addr == `CTU_OFF_IEN_SET) begin
        irq_en <= irq_en | (wdata[15:0] & `CTU_IEN_MASK);
      end
      if (rd && addr == `CTU_OFF_FLAGS) begin
        flags <= ev_flags;
      end else begin
        flags <= flags | ev_flags;
      end
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `CTU_OFF_CTRL:    rdata <= {28'h0, faulted, 1'b0, dir_down, enable};
          `CTU_OFF_EVCTRL:  rdata <= {25'h0, input1_event_behaviour, 1'b0,
                                      input0_event_behaviour};
          `CTU_OFF_IEN_CLR: rdata <= {16'h0, irq_en};
          `CTU_OFF_IEN_SET: rdata <= {16'h0, irq_en};
          `CTU_OFF_FLAGS:   rdata <= {16'h0, flags};
          `CTU_OFF_COUNT:   rdata <= {16'h0, count};
          `CTU_OFF_TOP:     rdata <= {16'h0, top};
          `CTU_OFF_DRV:     rdata <= {22'h0, permanent_fault_override_level, 6'h0,
                                      permanent_fault_override_en};
          `CTU_OFF_STATUS:  rdata <= {29'h0, state};
          `CTU_OFF_CB0:     rdata <= {16'h0, cb_all[15:0]};
          `CTU_OFF_CB0 + 8'h04: rdata <= {16'h0, cb_all[31:16]};
          `CTU_OFF_CV0:     rdata <= {16'h0, cv_all[15:0]};
          `CTU_OFF_CV0 + 8'h04: rdata <= {16'h0, cv_all[31:16]};
          default:          rdata <= 32'h0000_0000;
        endcase
      end
      wave_out  <= (faulted || fault_ev) ?
                   ((wave & ~permanent_fault_override_en) |
                    (permanent_fault_override_level & permanent_fault_override_en)) :
                   wave;
      count_out <= (w_ctrl && wdata[2]) ? {`CTU_CW{1'b0}} : next_count;
      irq       <= |((flags | ev_flags) & irq_en &
                     ~((rd && addr == `CTU_OFF_FLAGS) ? flags : 16'h0000));
    end
  end
endmodule // ctu_core

// ===== verif/ctu_core_properties.sv
// Purpose: Concurrent checks on the ctu_core ports
// Assumes: Register map of ctu_map.vh, one clock domain
// Notes:   Shadows enables, event setup and drive setup
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_core_properties (
  // Clock and reset
  input wire                mclk,
  input wire                rstn,
  // Register port
  input wire [7:0]          addr,
  input wire [31:0]         wdata,
  input wire                wr,
  input wire                rd,
  input wire [31:0]         rdata,
  // Events and outputs
  input wire                counter_event_line_a,
  input wire                counter_event_line_b,
  input wire [`CTU_NCH-1:0] wave_out,
  input wire [`CTU_CW-1:0]  count_out,
  input wire                irq
);
  reg [15:0] ien;
  reg [6:0]  ev;
  reg [9:0]  drv;
  reg        en;
  reg        dn;
  // Shadow of the written setup
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {ien, ev, drv, en, dn} <= 35'h0;
    end else if (wr) begin
      case (addr)
        `CTU_OFF_CTRL:    {dn, en} <= wdata[1:0];
        `CTU_OFF_EVCTRL:  ev <= wdata[6:0];
        `CTU_OFF_IEN_CLR: ien <= ien & ~wdata[15:0];
        `CTU_OFF_IEN_SET: ien <= ien | (wdata[15:0] & `CTU_IEN_MASK);
        `CTU_OFF_DRV:     drv <= wdata[9:0];
        default:          ;
      endcase
    end else if (ev[2:0] == `CTU_EV_FAULT && $rose(counter_event_line_a)) begin
      en <= 1'b0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_start_arm;
    wr && addr == `CTU_OFF_CTRL && wdata[0] && ev[2:0] == `CTU_EV_START;
  endsequence
  sequence s_fault_hit;
    ev[2:0] == `CTU_EV_FAULT && $rose(counter_event_line_a);
  endsequence
  a_clr_read: assert property (
    rd && addr == `CTU_OFF_IEN_CLR |=> rdata == {16'h0000, $past(ien)})
    else $error("clear view wrong");
  a_set_read: assert property (
    rd && addr == `CTU_OFF_IEN_SET |=> rdata == {16'h0000, $past(ien)})
    else $error("set view wrong");
  a_start_waits: assert property (
    s_start_arm ##1 (!counter_event_line_a)[*5] |-> $stable(count_out))
    else $error("counted before start event");
  a_no_restart: assert property (
    ev[2:0] == `CTU_EV_START && en && !dn |-> count_out >= $past(count_out))
    else $error("counter restarted");
  a_count_step: assert property (
    ev == 7'h05 && en |-> count_out == $past(count_out)
      || count_out == $past(count_out) + (dn ? 16'hFFFF : 16'h0001))
    else $error("bad count step");
  a_dir_level: assert property (
    ev[6:4] == `CTU_EV_DIR && ev[2:0] == `CTU_EV_COUNT && $past(counter_event_line_b, 2)
      && counter_event_line_b && count_out != $past(count_out)
      |-> count_out == $past(count_out) - 16'h0001)
    else $error("direction level ignored");
  a_incdec_step: assert property (
    ev == 7'h44 && en |-> count_out == $past(count_out)
      || count_out == $past(count_out) + 16'h0001 || count_out == $past(count_out) - 16'h0001)
    else $error("bad inc or dec step");
  a_fault_stop: assert property (
    s_fault_hit |-> ##[1:3] ($stable(count_out)
      && wave_out == (drv[9:8] & drv[1:0] | wave_out & ~drv[1:0]))[*3])
    else $error("fault did not stop and override");
endmodule // ctu_core_properties
bind ctu_core ctu_core_properties i_props (.mclk(mclk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .counter_event_line_a(counter_event_line_a),
  .counter_event_line_b(counter_event_line_b), .wave_out(wave_out), .count_out(count_out),
  .irq(irq));

// ===== verif/ctu_ev_fabric.sv
// Purpose: Event fabric model driving the two event lines
// Assumes: Lines change just after a rising edge
// Notes:   Pulse width and gap vary from one to three cycles
`timescale 1ns/1ps
module ctu_ev_fabric (
  // Clock
  input  wire  mclk,
  // Event lines
  output logic ev_a,
  output logic ev_b
);
  initial begin
    ev_a = 1'b0;
    ev_b = 1'b0;
  end
  // Held level on line B, changed just after a rising edge like the pulses
  task level_b(input logic v);
    @(posedge mclk);
    ev_b <= v;
  endtask
  // One event on A or B, both usable for the fault action
  task pulse(input logic on_b);
    int w;
    w = 1 + $urandom % 3;
    @(posedge mclk);
    if (on_b) ev_b <= 1'b1;
    else ev_a <= 1'b1;
    repeat (w) @(posedge mclk);
    if (on_b) ev_b <= 1'b0;
    else ev_a <= 1'b0;
    repeat (w) @(posedge mclk);
  endtask
endmodule // ctu_ev_fabric

// ===== verif/ctu_core_tb.sv
// Purpose: Self-checking bench for ctu_core
// Assumes: Register map of ctu_map.vh
// Notes:   Reads queue their expected word; a monitor compares
`timescale 1ns/1ps
`include "ctu_map.vh"
module ctu_core_tb;
  logic        mclk, rstn, wr, rd, rd_q, ev_a, ev_b, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  wave_out;
  logic [15:0] count_out, ex, v1;
  logic [15:0] clrv [5] = '{16'h0000, 16'h0800, 16'h0008, 16'h0005, 16'h0002};
  logic [31:0] exq [$];
  int          error_cnt, tests_run, n;
  ctu_core i_dut (
    .mclk                 (mclk),
    .rstn                 (rstn),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .counter_event_line_a (ev_a),
    .counter_event_line_b (ev_b),
    .wave_out             (wave_out),
    .count_out            (count_out),
    .irq                  (irq)
  );
  ctu_ev_fabric i_fab (
    .mclk (mclk),
    .ev_a (ev_a),
    .ev_b (ev_b)
  );
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exq.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Read data stands one cycle after the strobe
  always @(posedge mclk) begin
    rd_q <= rd;
    if (rd_q) chk(rdata, exq.pop_front());
  end
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    {rstn, wr, rd, addr, wdata} = 43'h0;
    void'($urandom(32'hA7BBE452));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rreg(`CTU_OFF_IEN_SET, 32'h0);
    rreg(8'hFC, 32'h0);
    wreg(`CTU_OFF_IEN_SET, 32'hFFFF);
    ex = `CTU_IEN_MASK;
    rreg(`CTU_OFF_IEN_CLR, {16'h0, ex});
    for (int i = 0; i < 5; i++) begin
      wreg(`CTU_OFF_IEN_CLR, {16'h0, clrv[i]});
      ex = ex & ~clrv[i];
      rreg(`CTU_OFF_IEN_SET, {16'h0, ex});
    end
    // Count action with the counter interrupt
    wreg(`CTU_OFF_IEN_SET, 32'h4);
    wreg(`CTU_OFF_EVCTRL, 32'h5);
    wreg(`CTU_OFF_CTRL, 32'h5);
    n = 5 + $urandom % 4;
    repeat (n) i_fab.pulse(1'b0);
    rreg(`CTU_OFF_COUNT, n);
    chk(irq, 32'h1);
    rreg(`CTU_OFF_FLAGS, 32'h4);
    wreg(`CTU_OFF_IEN_CLR, 32'h4);
    i_fab.pulse(1'b0);
    repeat (3) @(posedge mclk);
    chk(irq, 32'h0);
    rreg(`CTU_OFF_FLAGS, 32'h4);
    wreg(`CTU_OFF_CTRL, 32'h3);
    repeat (2) i_fab.pulse(1'b0);
    rreg(`CTU_OFF_COUNT, n - 1);
    // Direction from line B level
    wreg(`CTU_OFF_EVCTRL, 32'h25);
    wreg(`CTU_OFF_CTRL, 32'h1);
    i_fab.level_b(1'b1);
    repeat (3) i_fab.pulse(1'b0);
    rreg(`CTU_OFF_CTRL, 32'h3);
    rreg(`CTU_OFF_COUNT, n - 4);
    i_fab.level_b(1'b0);
    i_fab.pulse(1'b0);
    rreg(`CTU_OFF_COUNT, n - 3);
    // Increment on A and decrement on B, direction ignored
    wreg(`CTU_OFF_CTRL, 32'h4);
    wreg(`CTU_OFF_EVCTRL, 32'h44);
    wreg(`CTU_OFF_CTRL, 32'h3);
    repeat (4) i_fab.pulse(1'b0);
    i_fab.pulse(1'b1);
    rreg(`CTU_OFF_COUNT, 32'h3);
    // Start action
    wreg(`CTU_OFF_CTRL, 32'h4);
    wreg(`CTU_OFF_EVCTRL, 32'h3);
    wreg(`CTU_OFF_CTRL, 32'h1);
    repeat (6) @(posedge mclk);
    rreg(`CTU_OFF_COUNT, 32'h0);
    i_fab.pulse(1'b0);
    repeat (10) @(posedge mclk);
    v1 = count_out;
    i_fab.pulse(1'b0);
    chk(count_out > v1 + 16'h0002, 32'h1);
    // Double-buffered compare value
    wreg(`CTU_OFF_CTRL, 32'h4);
    wreg(`CTU_OFF_EVCTRL, 32'h0);
    wreg(`CTU_OFF_CB0, 32'h10);
    rreg(`CTU_OFF_CV0, 32'h0);
    rreg(`CTU_OFF_CB0, 32'h10);
    wreg(`CTU_OFF_CMD, {29'h0, `CTU_CMD_UPDATE});
    rreg(`CTU_OFF_CV0, 32'h10);
    chk(wave_out, 32'h1);
    // Fault action with override
    wreg(`CTU_OFF_DRV, 32'h203);
    wreg(`CTU_OFF_EVCTRL, 32'h7);
    wreg(`CTU_OFF_CTRL, 32'h1);
    i_fab.pulse(1'b0);
    v1 = count_out;
    repeat (3) @(posedge mclk);
    chk(count_out, v1);
    chk(wave_out, 32'h2);
    rreg(`CTU_OFF_CTRL, 32'h9);
    wreg(`CTU_OFF_CTRL, 32'h8);
    // Event action off
    wreg(`CTU_OFF_EVCTRL, 32'h0);
    wreg(`CTU_OFF_CTRL, 32'h5);
    repeat (4) @(posedge mclk);
    chk(count_out != 16'h0, 32'h1);
    repeat (3) @(posedge mclk);
    end_of_test;
  end
endmodule // ctu_core_tb
